// *** verif/fifo_side_model.sv ***
// Behavioural receive FIFO source and transmit word sink behind the host port.
`timescale 1ns/100ps
module fifo_side_model (
  input  wire logic        clk,
  input  wire logic        rx_pop,
  input  wire logic [15:0] tx_word,
  input  wire logic        tx_valid,
  input  wire logic        stall,
  output      logic [15:0] rx_word,
  output      logic        rx_valid,
  output      logic        tx_ready
);
  logic [15:0] rx_q[$];
  logic [15:0] tx_q[$];
  assign tx_ready = ~stall;
  initial rx_valid = 1'b0;
  initial rx_word = 16'h0000;
  // An empty head shows the inverse of the last word, so stale data never passes.
  task automatic refresh();
    rx_valid = rx_q.size() > 0;
    rx_word  = rx_valid ? rx_q[0] : ~rx_word;
  endtask : refresh
  task automatic push_rx(input logic [15:0] w);
    rx_q.push_back(w);
    refresh();
  endtask : push_rx
  always @(posedge clk) begin
    if (tx_valid && tx_ready) tx_q.push_back(tx_word);
    if (rx_pop && rx_q.size() > 0) begin
      void'(rx_q.pop_front());
      #1 refresh();
    end
  end
endmodule : fifo_side_model

// *** verif/tb_top.sv ***
// Self-checking bench for the host port: direct reads, register cycles and transmit stream.
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        host_select_low = 1'b1;
  logic        read_strobe_low = 1'b1;
  logic        write_strobe_low = 1'b1;
  logic        fifo_select = 1'b0;
  logic [7:1]  addr = 7'h00;
  logic [15:0] data_in = 16'h0000;
  logic [15:0] reg_rdata = 16'h0000;
  logic        stall = 1'b0;
  logic [15:0] data_out, rx_word, reg_wdata, tx_word, w;
  logic [7:1]  reg_addr;
  logic [1:0]  rx_lane;
  logic        data_oe_n, rx_valid, rx_pop, reg_rd_start, reg_rd_done, reg_wr, tx_valid, tx_ready, tx_overrun;
  logic [31:0] lfsr = 32'hf321;
  logic [15:0] exp_rx[$];
  logic [15:0] exp_tx[$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          mode = 0;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  // Either line may end a cycle, so the choice is random; the idle gap is two whole cycles.
  task automatic release_one();
    lfsr = lfsr_next(lfsr);
    if (lfsr[0]) host_select_low = 1'b1;
    else begin
      read_strobe_low = 1'b1;
      write_strobe_low = 1'b1;
    end
  endtask : release_one
  task automatic bus_rd(input logic fs, input logic [7:1] a, input logic [15:0] e, input logic pop);
    host_select_low = 1'b0;
    read_strobe_low = 1'b0;
    fifo_select = fs;
    addr = a;
    @(posedge clk); #1;
    reg_rdata = ~reg_rdata;
    check(reg_rd_start === !fs, "read start pulse");
    @(posedge clk); #1;
    check(data_out === e && data_oe_n === 1'b0, "read data");
    check(rx_lane === a[2:1] && (fs || reg_addr === a), "read lane");
    release_one();
    @(posedge clk); #1;
    check(rx_pop === pop && data_oe_n === 1'b1 && reg_rd_done === !fs, "read end");
    host_select_low = 1'b1;
    read_strobe_low = 1'b1;
    @(posedge clk); #1;
  endtask : bus_rd
  task automatic bus_wr(input logic fs, input logic [7:1] a, input logic [15:0] d, input logic ovr);
    host_select_low = 1'b0;
    write_strobe_low = 1'b0;
    fifo_select = fs;
    addr = a;
    data_in = ~d;
    @(posedge clk); #1;
    data_in = d;
    @(posedge clk); #1;
    release_one();
    data_in = ~d;
    @(posedge clk); #1;
    if (fs) check(tx_overrun === ovr, "overrun");
    else check(reg_wr === 1'b1 && reg_wdata === d && reg_addr === a, "reg write");
    if (fs && !ovr) exp_tx.push_back(d);
    host_select_low = 1'b1;
    write_strobe_low = 1'b1;
    @(posedge clk); #1;
  endtask : bus_wr
  ////////////////////////////////////////////////////////////////////////////////
  // Mode one stalls four cycles in eight; a write takes four, so the tail entry fills but drains before the next write.
  always @(posedge clk) begin
    cyc++;
    #1 stall = (mode == 2) || (mode == 1 && cyc[2]);
    if (cyc == 2000) begin
      mismatches++;
      finish_test();
    end
  end
  host_port uut (.clk(clk), .rst_n(rst_n), .host_select_low(host_select_low), .read_strobe_low(read_strobe_low),
    .write_strobe_low(write_strobe_low), .fifo_select(fifo_select), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .rx_word(rx_word), .rx_valid(rx_valid), .rx_pop(rx_pop),
    .rx_lane(rx_lane), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_rd_start(reg_rd_start),
    .reg_rd_done(reg_rd_done), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_overrun(tx_overrun));
  fifo_side_model mdl (.clk(clk), .rx_pop(rx_pop), .tx_word(tx_word), .tx_valid(tx_valid), .stall(stall),
    .rx_word(rx_word), .rx_valid(rx_valid), .tx_ready(tx_ready));
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    check(data_oe_n === 1'b1 && tx_valid === 1'b0 && rx_pop === 1'b0, "reset state");
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      exp_rx.push_back(lfsr[15:0]);
      mdl.push_rx(lfsr[15:0]);
    end
    for (int i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      w = (exp_rx.size() > 0) ? exp_rx[0] : host_port_pkg::EMPTY_WORD;
      bus_rd(1'b1, lfsr[22:16], w, exp_rx.size() > 0);
      if (exp_rx.size() > 0) void'(exp_rx.pop_front());
    end
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      reg_rdata = lfsr[31:16];
      if (i < 3) bus_rd(1'b0, lfsr[22:16], lfsr[31:16], 1'b0);
      else bus_wr(1'b0, lfsr[22:16], lfsr[15:0], 1'b0);
    end
    mode = 1;
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      if (i == 6) begin
        mode = 0;
        repeat (4) @(posedge clk);
        #1 mode = 2;
      end
      bus_wr(1'b1, lfsr[22:16], lfsr[15:0], i >= 8);
    end
    mode = 0;
    repeat (8) @(posedge clk);
    #1;
    check(mdl.tx_q.size() == exp_tx.size(), "tx count");
    foreach (exp_tx[i]) check(mdl.tx_q[i] === exp_tx[i], "tx word");
    finish_test();
  end
endmodule : tb_top

// *** verilog/host_port.sv ***
// Asynchronous 16-bit host port with direct receive and transmit FIFO modes.
`timescale 1ns/100ps
module host_port #(
  parameter int DW = host_port_pkg::DATA_W
) (
  input  wire logic                                           clk,
  input  wire logic                                           rst_n,
  input  wire logic                                           host_select_low,
  input  wire logic                                           read_strobe_low,
  input  wire logic                                           write_strobe_low,
  input  wire logic                                           fifo_select,
  input  wire logic [host_port_pkg::ADDR_HI:host_port_pkg::ADDR_LO] addr,
  input  wire logic [DW-1:0]                                  data_in,
  output      logic [DW-1:0]                                  data_out,
  output      logic                                           data_oe_n,
  input  wire logic [DW-1:0]                                  rx_word,
  input  wire logic                                           rx_valid,
  output      logic                                           rx_pop,
  output      logic [host_port_pkg::LANE_HI-1:0]              rx_lane,
  input  wire logic [DW-1:0]                                  reg_rdata,
  output      logic [host_port_pkg::ADDR_HI:host_port_pkg::ADDR_LO] reg_addr,
  output      logic                                           reg_rd_start,
  output      logic                                           reg_rd_done,
  output      logic                                           reg_wr,
  output      logic [DW-1:0]                                  reg_wdata,
  output      logic [DW-1:0]                                  tx_word,
  output      logic                                           tx_valid,
  input  wire logic                                           tx_ready,
  output      logic                                           tx_overrun
);
  logic          rd_active;
  logic          wr_active;
  logic          rd_busy;
  logic          wr_busy;
  logic          rd_start;
  logic          rd_end;
  logic          wr_start;
  logic          wr_end;
  logic          rd_dir;
  logic          wr_dir;
  logic          rd_had_word;
  logic [DW-1:0] wr_data_q;

  word_buf_if #(.W(DW)) tx_in ();
  word_buf_if #(.W(DW)) tx_out ();

  ////////////////////////////////////////////////////////////////////////////
  // Cycle framing from the strobe pairs, in any order of assertion.
  assign rd_active = !host_select_low && !read_strobe_low;
  assign wr_active = !host_select_low && !write_strobe_low && !rd_active;
  assign rd_start  = rd_active && !rd_busy;
  assign rd_end    = !rd_active && rd_busy;
  assign wr_start  = wr_active && !wr_busy;
  assign wr_end    = !wr_active && wr_busy;

  // A one-clock idle gap suffices because inputs are sampled once a period.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
    end else begin
      rd_busy <= rd_active;
      wr_busy <= wr_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and address are taken once at cycle start and held to its end.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_dir   <= 1'b0;
      wr_dir   <= 1'b0;
      reg_addr <= host_port_pkg::ADDR_RESET;
      rx_lane  <= '0;
    end else begin
      if (rd_start) begin
        rd_dir <= fifo_select;
        rx_lane <= addr[host_port_pkg::LANE_HI:host_port_pkg::ADDR_LO];
        if (!fifo_select) begin
          reg_addr <= addr;
        end
      end
      if (wr_start) begin
        wr_dir <= fifo_select;
        if (!fifo_select) begin
          reg_addr <= addr;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: the snapshot at cycle start keeps counter values coherent.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out    <= host_port_pkg::EMPTY_WORD;
      data_oe_n   <= 1'b1;
      rd_had_word <= 1'b0;
    end else begin
      if (rd_start) begin
        data_oe_n <= 1'b0;
        if (fifo_select) begin
          data_out    <= rx_valid ? rx_word : host_port_pkg::EMPTY_WORD;
          rd_had_word <= rx_valid;
        end else begin
          data_out    <= reg_rdata;
          rd_had_word <= 1'b0;
        end
      end else if (rd_end) begin
        data_oe_n <= 1'b1;
      end
    end
  end

  // Popping at the end lets a burst run as long as the host keeps cycling.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_pop       <= 1'b0;
      reg_rd_start <= 1'b0;
      reg_rd_done  <= 1'b0;
    end else begin
      rx_pop       <= rd_end && rd_dir && rd_had_word;
      reg_rd_start <= rd_start && !fifo_select;
      reg_rd_done  <= rd_end && !rd_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data follow the bus while the cycle runs; the last sample wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_data_q <= host_port_pkg::EMPTY_WORD;
    end else if (wr_active) begin
      wr_data_q <= data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_wr    <= 1'b0;
      reg_wdata <= host_port_pkg::EMPTY_WORD;
    end else begin
      reg_wr <= wr_end && !wr_dir;
      if (wr_end && !wr_dir) begin
        reg_wdata <= wr_data_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direct writes enter the buffer; a host cannot be stalled, so a full
  // buffer drops the word and flags it for one clock.
  assign tx_in.valid  = wr_end && wr_dir;
  assign tx_in.data   = wr_data_q;
  assign tx_out.ready = tx_ready;

  word_buffer #(.W(DW)) u_tx_buffer (
    .clk      (clk),
    .rst_n    (rst_n),
    .in_port  (tx_in.snk),
    .out_port (tx_out.src)
  );

  assign tx_word  = tx_out.data;
  assign tx_valid = tx_out.valid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_overrun <= 1'b0;
    end else begin
      tx_overrun <= tx_in.valid && !tx_in.ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rx_direct_data: assert property (rd_start && fifo_select && rx_valid |=> data_out == $past(rx_word))
    else $error("Direct read did not return the receive word.");
  a_lane_low_bits: assert property (rd_start |=> rx_lane == $past(addr[2:1]))
    else $error("Low address bits not kept on read.");
  a_lane_held: assert property (!rd_start |=> $stable(rx_lane))
    else $error("Lane changed outside a read start.");
  a_burst_pop_each: assert property (rd_end && rd_dir && rd_had_word |=> rx_pop ##1 !rx_pop)
    else $error("Burst read cycle did not pop exactly once.");
  // An empty buffer must show the pushed word downstream one clock later.
  a_tx_push_word: assert property (wr_end && wr_dir && !tx_valid |=> tx_valid && tx_word == $past(wr_data_q))
    else $error("Direct write did not push the captured word.");
  a_overrun_flag: assert property (wr_end && wr_dir && !tx_in.ready |=> tx_overrun)
    else $error("Dropped direct write not flagged.");
  a_read_drive_span: assert property (rd_busy |-> !data_oe_n)
    else $error("Data bus drive does not follow the read cycle.");
  a_read_drive_off: assert property (!rd_busy |-> data_oe_n)
    else $error("Data bus driven outside a read cycle.");
  a_write_end_once: assert property ($fell(wr_active) && wr_busy |-> wr_end ##1 !wr_end)
    else $error("Write cycle end not seen once.");
  a_write_data_last: assert property (wr_active ##1 wr_end |-> tx_in.data == $past(data_in))
    else $error("Write data not taken from the last sample.");
  a_reg_write_pulse: assert property (wr_end && !wr_dir |=> reg_wr && reg_wdata == $past(wr_data_q))
    else $error("Register write not issued with the captured word.");
  a_reg_read_pulse: assert property (rd_start && !fifo_select |=> reg_rd_start)
    else $error("Register read start not signalled.");
  a_freeze_reg_read: assert property (rd_busy && !rd_dir && !rd_start && $past(rd_busy) |-> $stable(data_out))
    else $error("Register read data changed inside its cycle.");
  a_pop_needs_end: assert property (rx_pop |-> $past(rd_end) && $past(rd_dir))
    else $error("Receive pop outside a direct read end.");
endmodule : host_port

// *** verilog/host_port_pkg.sv ***
// Constants shared by the asynchronous host port and its transmit buffer.
package host_port_pkg;
  localparam int DATA_W          = 16;
  localparam int ADDR_HI         = 7;
  localparam int ADDR_LO         = 1;
  localparam int LANE_HI         = 2;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int DEASSERT_MIN_NS = 13;
  localparam int DATA_SETUP_NS   = 7;
  // Least times round up to whole cycles and never fall below one cycle.
  localparam int DEASSERT_MIN_CYC_RAW = (DEASSERT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEASSERT_MIN_CYC     = (DEASSERT_MIN_CYC_RAW < 1) ? 1 : DEASSERT_MIN_CYC_RAW;
  localparam int DATA_SETUP_CYC_RAW   = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC       = (DATA_SETUP_CYC_RAW < 1) ? 1 : DATA_SETUP_CYC_RAW;
  localparam logic [DATA_W-1:0] EMPTY_WORD = 16'h0000;
  localparam logic [ADDR_HI:ADDR_LO] ADDR_RESET = 7'h00;
endpackage : host_port_pkg

// *** verilog/word_buf_if.sv ***
// Valid and ready word channel between the host port and its transmit buffer.
`timescale 1ns/100ps
interface word_buf_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : word_buf_if

// *** verilog/word_buffer.sv ***
// Two-entry buffer whose head entry register drives the outgoing word.
`timescale 1ns/100ps
module word_buffer #(
  parameter int W = host_port_pkg::DATA_W
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  word_buf_if.snk     in_port,
  word_buf_if.src     out_port
);
  logic [W-1:0] head;
  logic [W-1:0] tail;
  logic         head_v;
  logic         tail_v;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // A full buffer refuses new words so the source sees the stall.
  assign in_port.ready  = !tail_v;
  assign push           = in_port.valid && !tail_v;
  assign pop            = out_port.ready && head_v;
  assign out_port.data  = head;
  assign out_port.valid = head_v;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head   <= '0;
      tail   <= '0;
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else if (pop && tail_v) begin
      head   <= tail;
      tail_v <= 1'b0;
    end else if (pop && push) begin
      head   <= in_port.data;
    end else if (pop) begin
      head_v <= 1'b0;
    end else if (push && !head_v) begin
      head   <= in_port.data;
      head_v <= 1'b1;
    end else if (push) begin
      tail   <= in_port.data;
      tail_v <= 1'b1;
    end
  end
endmodule : word_buffer
